// ---- core/psc_cfg.sv ----
// Configuration, control and waveform engine of the third power stage controller,
// with run/chained-start state for all three units of the ring.
// Assumes an 8-bit register port driven on sys_clk; clock and fault pins are asynchronous.
`timescale 1ns/1ps
`include "psc_cfg_map.svh"
module psc_cfg (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire psc_cfg_pkg::psc_bus_t bus,
  output logic [7:0] rdata,
  input wire logic fast_clock_input,
  input wire logic slow_clock_input,
  input wire logic dedicated_fault_input_pin,
  input wire logic comparator_output,
  output logic [1:0] waveform_output_a,
  output logic [1:0] waveform_output_a_oe,
  output logic [1:0] waveform_output_b,
  output logic [1:0] waveform_output_b_oe,
  output logic [3:0] compare_match,
  output logic cycle_end,
  output logic [2:0] unit_run,
  output logic capture_event,
  output logic [11:0] capture_value
);
  psc_cfg_pkg::psc_state_t s;
  psc_cfg_pkg::psc_state_t n;
  psc_cfg_pkg::psc_mode_t mode;
  logic [3:0] rise;
  logic src_rise;
  logic tick;
  logic [5:0] lim;
  logic carry;
  logic [11:0] ra_x;
  logic [11:0] rb_x;
  logic [11:0] endv;
  logic [1:0] last;
  logic end_now;
  logic act_a;
  logic act_b;
  logic lvl_a;
  logic lvl_b;
  logic upd;
  logic [2:0] r;
  logic [2:0] a;
  logic [2:0] want;
  logic ev_a;
  logic ev_b;
  logic fault_a;
  logic fault_b;

  always_comb begin
    n = s;
    n.sync1 = {comparator_output, dedicated_fault_input_pin, slow_clock_input,
               fast_clock_input};
    n.sync2 = s.sync1;
    n.sync3 = s.sync2;
    rise = s.sync2 & ~s.sync3;
    mode = psc_cfg_pkg::psc_mode_t'(s.cnf2[`PSC_CNF_MODE_HI:`PSC_CNF_MODE_LO]);
    // Source clocks are sampled pins, so the engine steps on their rising edges
    src_rise = s.cnf2[`PSC_CNF_CLKSEL] ? rise[0] : rise[1];
    case (s.ctl2[`PSC_CTL_PRE_HI:`PSC_CTL_PRE_LO])
      2'h0: lim = `PSC_DIV1_LAST;
      2'h1: lim = `PSC_DIV4_LAST;
      2'h2: lim = `PSC_DIV16_LAST;
      default: lim = `PSC_DIV64_LAST;
    endcase
    tick = src_rise && (s.pre == lim);
    if (src_rise) begin
      n.pre = (s.pre == lim) ? 6'h00 : s.pre + 6'h01;
    end
    // Fraction carry stretches the second on-time end, and the first too when balanced, by one count this cycle
    carry = s.acc[4];
    ra_x = s.act.ra + {11'h000, carry & s.ctl2[`PSC_CTL_BFM]};
    rb_x = s.act.rb + {11'h000, carry};
    case (mode)
      psc_cfg_pkg::psc_one_ramp: begin
        endv = rb_x;
        last = 2'h0;
      end
      psc_cfg_pkg::psc_two_ramp: begin
        endv = s.ramp[0] ? rb_x : ra_x;
        last = 2'h1;
      end
      psc_cfg_pkg::psc_four_ramp: begin
        last = 2'h3;
        case (s.ramp)
          2'h0: endv = s.act.sa;
          2'h1: endv = ra_x;
          2'h2: endv = s.act.sb;
          default: endv = rb_x;
        endcase
      end
      default: begin
        endv = rb_x;
        last = 2'h0;
      end
    endcase
    end_now = 1'b0;
    if (s.running && tick) begin
      if (mode == psc_cfg_pkg::psc_centred) begin
        if (!s.down) begin
          if (s.cnt >= endv) begin
            n.down = 1'b1;
          end else begin
            n.cnt = s.cnt + 12'h001;
          end
        end else if (s.cnt == 12'h000) begin
          n.down = 1'b0;
          end_now = 1'b1;
        end else begin
          n.cnt = s.cnt - 12'h001;
        end
      end else if (s.cnt >= endv) begin
        n.cnt = 12'h000;
        if (s.ramp == last) begin
          n.ramp = 2'h0;
          end_now = 1'b1;
        end else begin
          n.ramp = s.ramp + 2'h1;
        end
      end else begin
        n.cnt = s.cnt + 12'h001;
      end
    end
    n.cyc_end = end_now;
    if (end_now) begin
      n.acc = {1'b0, s.acc[3:0]} + {1'b0, s.act.frac};
    end
    // Each counter step compares all four registers
    n.match = 4'h0;
    if (s.running && tick) begin
      n.match = {s.cnt == s.act.rb, s.cnt == s.act.sb, s.cnt == s.act.ra,
                 s.cnt == s.act.sa};
    end
    case (mode)
      psc_cfg_pkg::psc_one_ramp: begin
        act_a = (s.cnt >= s.act.sa) && (s.cnt < ra_x);
        act_b = (s.cnt >= s.act.sb) && (s.cnt < rb_x);
      end
      psc_cfg_pkg::psc_two_ramp: begin
        act_a = (s.ramp == 2'h0) && (s.cnt >= s.act.sa);
        act_b = (s.ramp == 2'h1) && (s.cnt >= s.act.sb);
      end
      psc_cfg_pkg::psc_four_ramp: begin
        act_a = (s.ramp == 2'h1);
        act_b = (s.ramp == 2'h3);
      end
      default: begin
        act_a = s.cnt >= s.act.sa;
        act_b = s.cnt < s.act.sb;
      end
    endcase
    act_a = act_a && s.running;
    act_b = act_b && s.running;
    if (s.cnf2[`PSC_CNF_OME]) begin
      lvl_a = s.running && s.act.mtx[{1'b0, s.ramp}];
      lvl_b = s.running && s.act.mtx[{1'b1, s.ramp}];
    end else begin
      lvl_a = ~(s.cnf2[`PSC_CNF_POL] ^ act_a);
      lvl_b = ~(s.cnf2[`PSC_CNF_POL] ^ act_b);
    end
    n.out_a = {2{lvl_a}};
    n.out_b = {2{lvl_b}};
    n.idle = s.cnf2[`PSC_CNF_OME] ? 1'b0 : ~s.cnf2[`PSC_CNF_POL];
    // Ring of three: unit i follows unit i-1
    r = {s.ctl2[`PSC_CTL_RUN], s.ctl1[`PSC_CTL_RUN], s.ctl0[`PSC_CTL_RUN]};
    a = {s.ctl2[`PSC_CTL_ARUN], s.ctl1[`PSC_CTL_ARUN], s.ctl0[`PSC_CTL_ARUN]};
    for (int i = 0; i < 3; i++) begin
      want[i] = r[i] | (a[i] & (r[(i + 2) % 3] | (a[(i + 2) % 3] & r[(i + 1) % 3])));
    end
    n.run = want;
    if (want[2]) begin
      n.running = 1'b1;
    end else if (s.running && !(s.ctl2[`PSC_CTL_CCYC] && !s.ctl2[`PSC_CTL_ARUN] && !end_now)) begin
      n.running = 1'b0;
      n.cnt = 12'h000;
      n.ramp = 2'h0;
      n.down = 1'b0;
    end
    ev_a = s.frca[`PSC_FRC_ISEL] ? rise[3] : rise[2];
    ev_b = s.frcb[`PSC_FRC_ISEL] ? rise[3] : rise[2];
    n.cap_evt = (s.frca[`PSC_FRC_CAE] && ev_a) || (s.frcb[`PSC_FRC_CAE] && ev_b);
    if (n.cap_evt) begin
      n.cap = s.cnt;
    end
    // Held copies move to the engine; auto hold wins over manual hold
    upd = s.cnf2[`PSC_CNF_ALOCK] ? (s.cyc_end && s.rb_last) : !s.cnf2[`PSC_CNF_LOCK];
    if (upd) begin
      n.act = s.sw;
      if (s.cnf2[`PSC_CNF_ALOCK]) begin
        n.rb_last = 1'b0;
      end
    end
    n.rdata = 8'h00;
    if (bus.wr) begin
      case (bus.addr)
        `PSC_A_SA_H, `PSC_A_RA_H, `PSC_A_SB_H, `PSC_A_RB_H: n.temp = bus.wdata;
        `PSC_A_SA_L: begin
          n.sw.sa = {s.temp[3:0], bus.wdata};
          n.rb_last = 1'b0;
        end
        `PSC_A_RA_L: begin
          n.sw.ra = {s.temp[3:0], bus.wdata};
          n.rb_last = 1'b0;
        end
        `PSC_A_SB_L: begin
          n.sw.sb = {s.temp[3:0], bus.wdata};
          n.rb_last = 1'b0;
        end
        `PSC_A_RB_L: begin
          n.sw.rb = {s.temp[3:0], bus.wdata};
          n.sw.frac = s.temp[7:4];
          n.rb_last = 1'b1;
          if (s.cnf2[`PSC_CNF_FIFTY]) begin
            n.sw.ra = {s.temp[3:0], bus.wdata};
            n.sw.sa = s.sw.sb;
          end
        end
        `PSC_A_CNF0: n.cnf0 = bus.wdata;
        `PSC_A_CNF2: n.cnf2 = bus.wdata;
        `PSC_A_CTL0: n.ctl0 = bus.wdata;
        `PSC_A_CTL1: n.ctl1 = bus.wdata;
        `PSC_A_CTL2: n.ctl2 = bus.wdata;
        `PSC_A_FRCA: n.frca = bus.wdata;
        `PSC_A_FRCB: n.frcb = bus.wdata;
        `PSC_A_OCFG: begin
          n.sw.ocfg = bus.wdata;
          n.rb_last = 1'b0;
        end
        `PSC_A_MTX: begin
          n.sw.mtx = bus.wdata;
          n.rb_last = 1'b0;
        end
        default: n.temp = s.temp;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        `PSC_A_SA_L: n.rdata = s.sw.sa[7:0];
        `PSC_A_SA_H: n.rdata = {4'h0, s.sw.sa[11:8]};
        `PSC_A_RA_L: n.rdata = s.sw.ra[7:0];
        `PSC_A_RA_H: n.rdata = {4'h0, s.sw.ra[11:8]};
        `PSC_A_SB_L: n.rdata = s.sw.sb[7:0];
        `PSC_A_SB_H: n.rdata = {4'h0, s.sw.sb[11:8]};
        `PSC_A_RB_L: n.rdata = s.sw.rb[7:0];
        `PSC_A_RB_H: n.rdata = {s.sw.frac, s.sw.rb[11:8]};
        `PSC_A_CNF0: n.rdata = s.cnf0;
        `PSC_A_CNF2: n.rdata = s.cnf2;
        `PSC_A_CTL0: n.rdata = s.ctl0;
        `PSC_A_CTL1: n.rdata = s.ctl1;
        `PSC_A_CTL2: n.rdata = s.ctl2;
        `PSC_A_FRCA: n.rdata = s.frca;
        `PSC_A_FRCB: n.rdata = s.frcb;
        `PSC_A_OCFG: n.rdata = s.sw.ocfg;
        `PSC_A_MTX: n.rdata = s.sw.mtx;
        `PSC_A_CAP_L: n.rdata = s.cap[7:0];
        `PSC_A_CAP_H: n.rdata = {4'h0, s.cap[11:8]};
        `PSC_A_STAT: n.rdata = {2'h0, s.ramp, s.down, s.run};
        default: n.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Fault path bypasses every flip-flop so a fault acts even with a stalled clock
  assign fault_a = s.frca[`PSC_FRC_ISEL] ? comparator_output : dedicated_fault_input_pin;
  assign fault_b = s.frcb[`PSC_FRC_ISEL] ? comparator_output : dedicated_fault_input_pin;
  assign waveform_output_a = (s.ctl2[`PSC_CTL_AOCA] && fault_a) ? {2{s.idle}} : s.out_a;
  assign waveform_output_b = (s.ctl2[`PSC_CTL_AOCB] && fault_b) ? {2{s.idle}} : s.out_b;
  assign waveform_output_a_oe = {s.act.ocfg[1], s.act.ocfg[0]};
  assign waveform_output_b_oe = {s.act.ocfg[3], s.act.ocfg[2]};
  assign rdata = s.rdata;
  assign compare_match = s.match;
  assign cycle_end = s.cyc_end;
  assign unit_run = s.run;
  assign capture_event = s.cap_evt;
  assign capture_value = s.cap;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence rb_commit_s;
    bus.wr && bus.addr == `PSC_A_RB_L && s.cnf2[`PSC_CNF_FIFTY];
  endsequence
  high_byte_commit_a: assert property (bus.wr && bus.addr == `PSC_A_SA_L |=>
    s.sw.sa == {$past(s.temp[3:0]), $past(bus.wdata)}) else $error("sa commit wrong");
  half_duty_copy_a: assert property (rb_commit_s |=>
    s.sw.ra == s.sw.rb && s.sw.sa == $past(s.sw.sb)) else $error("half duty copy lost");
  manual_hold_a: assert property (s.cnf2[`PSC_CNF_LOCK] && !s.cnf2[`PSC_CNF_ALOCK] |=>
    s.act == $past(s.act)) else $error("engine copy moved under hold");
  auto_hold_a: assert property (s.cnf2[`PSC_CNF_ALOCK] && !(s.cyc_end && s.rb_last) |=>
    $stable(s.act)) else $error("auto hold updated early");
  idle_polarity_a: assert property (!s.running && !s.cnf2[`PSC_CNF_OME] ##1
    $stable(s.cnf2) |-> s.out_a == {2{~s.cnf2[`PSC_CNF_POL]}}) else $error("idle level wrong");
  divide_four_a: assert property (tick && s.ctl2[7:6] == 2'h1 && $stable(s.ctl2) |=>
    !tick [*7]) else $error("divide by four too fast");
  chained_start_a: assert property (s.ctl2[`PSC_CTL_ARUN] && s.ctl1[`PSC_CTL_RUN] |=>
    s.run[2] && s.running) else $error("chained start missed");
  run_start_a: assert property (s.ctl2[`PSC_CTL_RUN] |=> s.running)
    else $error("run request did not start");
  finish_cycle_a: assert property (s.running && !want[2] && s.ctl2[`PSC_CTL_CCYC] &&
    !s.ctl2[`PSC_CTL_ARUN] && !end_now |=> s.running) else $error("halted mid cycle");
  capture_pin_a: assert property (s.frca[7:6] == 2'h2 && rise[2] |=>
    capture_event && capture_value == $past(s.cnt)) else $error("capture missed");
endmodule

// ---- core/psc_cfg_map.svh ----
// Offsets, field positions, reset values and counts of the power stage controller block.
// Assumes an 8-bit register port with one-cycle strobes; offsets are register indices.
//
// What this block does
// - Four compare registers hold 12-bit values compared with the counter each step.
// - A compare match pulses a request and shapes the tied waveform output.
// - Last reset compare also holds a 4-bit fraction for flank width modulation.
// - Compare writes go through one shared 8-bit high byte, committed together.
// - Half duty mode copies second-part compares into first-part ones on the reset B low byte write.
// - Auto update hold applies buffered writes at cycle end if reset B written last.
// - Auto update hold prevails over manual update hold when both are set.
// - Manual update hold keeps buffered writes until the hold bit is cleared.
// - Mode field bits 4:3: one ramp, two ramp, four ramp, centre aligned.
// - Polarity bit cleared gives active low outputs, set gives active high.
// - Clock select bit set picks the fast clock input, cleared the slow.
// - Third unit matrix enable drives outputs from the matrix, polarity ignored.
// - Divider field divides the input clock by 1, 4, 16 or 64.
// - Balanced bit cleared modulates second on-time only, set modulates both.
// - Async fault control lets the fault input force that part's pins directly.
// - Chained start follows the ring predecessor's run, or its chained predecessor.
// - Writing one to the run request bit starts the unit.
// - Run request takes precedence over the same unit's chained start bit.
// - Finish-cycle bit completes the current cycle after run clears, unless chained.
// - Two identical input blocks A and B, each with its own control register.
// - Capture enable makes an event on the selected input capture the counter.
// - Input select picks the dedicated pin when cleared, comparator when set.
`ifndef PSC_CFG_MAP_SVH
`define PSC_CFG_MAP_SVH
`define PSC_AW 5
`define PSC_A_SA_L 5'h00
`define PSC_A_SA_H 5'h01
`define PSC_A_RA_L 5'h02
`define PSC_A_RA_H 5'h03
`define PSC_A_SB_L 5'h04
`define PSC_A_SB_H 5'h05
`define PSC_A_RB_L 5'h06
`define PSC_A_RB_H 5'h07
`define PSC_A_CNF0 5'h08
`define PSC_A_CNF2 5'h09
`define PSC_A_CTL0 5'h0a
`define PSC_A_CTL1 5'h0b
`define PSC_A_CTL2 5'h0c
`define PSC_A_FRCA 5'h0d
`define PSC_A_FRCB 5'h0e
`define PSC_A_OCFG 5'h0f
`define PSC_A_MTX 5'h10
`define PSC_A_CAP_L 5'h11
`define PSC_A_CAP_H 5'h12
`define PSC_A_STAT 5'h13
`define PSC_CNF_FIFTY 7
`define PSC_CNF_ALOCK 6
`define PSC_CNF_LOCK 5
`define PSC_CNF_MODE_HI 4
`define PSC_CNF_MODE_LO 3
`define PSC_CNF_POL 2
`define PSC_CNF_CLKSEL 1
`define PSC_CNF_OME 0
`define PSC_CTL_PRE_HI 7
`define PSC_CTL_PRE_LO 6
`define PSC_CTL_BFM 5
`define PSC_CTL_AOCB 4
`define PSC_CTL_AOCA 3
`define PSC_CTL_ARUN 2
`define PSC_CTL_CCYC 1
`define PSC_CTL_RUN 0
`define PSC_FRC_CAE 7
`define PSC_FRC_ISEL 6
`define PSC_DIV1_LAST 6'h00
`define PSC_DIV4_LAST 6'h03
`define PSC_DIV16_LAST 6'h0f
`define PSC_DIV64_LAST 6'h3f
`define PSC_RESET_REG 8'h00
`endif

// ---- core/psc_cfg_pkg.sv ----
// Types of the power stage controller block: bus carrier, modes and the state record.
// Assumes psc_cfg_map.svh supplies all numbers.
package psc_cfg_pkg;
  typedef enum logic [1:0] {psc_one_ramp, psc_two_ramp, psc_four_ramp, psc_centred} psc_mode_t;
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } psc_bus_t;
  typedef struct packed {
    logic [11:0] sa;
    logic [11:0] ra;
    logic [11:0] sb;
    logic [11:0] rb;
    logic [3:0] frac;
    logic [7:0] ocfg;
    logic [7:0] mtx;
  } psc_shadow_t;
  typedef struct packed {
    psc_shadow_t sw;
    psc_shadow_t act;
    logic [7:0] temp;
    logic [7:0] cnf0;
    logic [7:0] cnf2;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] frca;
    logic [7:0] frcb;
    logic rb_last;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [5:0] pre;
    logic [11:0] cnt;
    logic [1:0] ramp;
    logic down;
    logic running;
    logic [4:0] acc;
    logic [2:0] run;
    logic cyc_end;
    logic [3:0] match;
    logic [11:0] cap;
    logic cap_evt;
    logic [1:0] out_a;
    logic [1:0] out_b;
    logic idle;
    logic [7:0] rdata;
  } psc_state_t;
endpackage

// ---- verification/psc_cfg_stage.sv ----
// Stage model: the two clock pins that the power stage controller steps on.
// Assumes the bench gates each pin; a gated pin finishes its high phase and rests low.
`timescale 1ns/1ps
module psc_cfg_stage (
  input wire logic fast_on,
  input wire logic slow_on,
  output logic fast_clock_input,
  output logic slow_clock_input,
  output int edges
);
  initial begin
    fast_clock_input = 1'b0;
    slow_clock_input = 1'b0;
    edges = 0;
  end
  always begin
    #20;
    if (fast_on || fast_clock_input) fast_clock_input = ~fast_clock_input;
  end
  always begin
    #35;
    if (slow_on || slow_clock_input) slow_clock_input = ~slow_clock_input;
  end
  // One counter for both pins; the bench runs only one pin while it counts
  always @(posedge fast_clock_input or posedge slow_clock_input) begin
    edges++;
  end
endmodule

// ---- verification/tb.sv ----
// Self-checking bench of the power stage controller configuration block.
// Assumes the stage model makes the clock pins; fault and comparator levels are driven here.
`timescale 1ns/1ps
`include "psc_cfg_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: line %0d got %h want %h", $time, `__LINE__, g, e); end end
module tb;
  logic sys_clk, rst_b, fast_on, slow_on, fault_pin, cmp_out, cyc_end, cap_evt, f;
  logic fast_clk, slow_clk;
  psc_cfg_pkg::psc_bus_t bus;
  logic [7:0] rdata, q;
  logic [1:0] out_a, out_b, oe_a, oe_b, seen;
  logic [2:0] unit_run;
  logic [6:0] snap;
  logic [3:0] cmatch, m_seen;
  logic [11:0] cap_val;
  int edges, mismatches, num_checks, n0, n, s;
  int fac[4] = '{1, 4, 16, 64};

  psc_cfg dut (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .fast_clock_input(fast_clk), .slow_clock_input(slow_clk),
    .dedicated_fault_input_pin(fault_pin), .comparator_output(cmp_out),
    .waveform_output_a(out_a), .waveform_output_a_oe(oe_a), .waveform_output_b(out_b),
    .waveform_output_b_oe(oe_b), .compare_match(cmatch), .cycle_end(cyc_end),
    .unit_run(unit_run), .capture_event(cap_evt), .capture_value(cap_val));
  psc_cfg_stage stage (.fast_on(fast_on), .slow_on(slow_on), .fast_clock_input(fast_clk),
    .slow_clock_input(slow_clk), .edges(edges));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Two cycles per access, so the strobe never drops and rises in one time step
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge sys_clk);
    bus <= '0;
    @(negedge sys_clk);
    q = rdata;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask
  // High byte through the shared holding byte first, low byte commits
  task automatic wcmp(input logic [4:0] a, input logic [11:0] v);
    wr(a + 5'h01, {4'h0, v[11:8]});
    wr(a, v[7:0]);
  endtask
  // Waits for an end of cycle, gathering the part A levels seen meanwhile
  task automatic wait_ev(input int lim, output logic hit);
    hit = 1'b0;
    seen = 2'b00;
    for (int i = 0; i < lim && !hit; i++) begin
      @(negedge sys_clk);
      seen |= out_a;
      hit = (cyc_end === 1'b1);
    end
    @(posedge sys_clk);
  endtask
  task automatic wait_end();
    wait_ev(4000, f);
    if (!f) begin
      mismatches++;
      $display("mismatch at %0t: no end of cycle", $time);
      close_out();
    end
  endtask
  task automatic look();
    @(negedge sys_clk);
    snap = {unit_run, out_a, out_b};
    @(posedge sys_clk);
  endtask
  task automatic per_cycle(output int cnt);
    wait_end();
    s = edges;
    wait_end();
    cnt = edges - s;
  endtask
  // Auto hold updates only on cycle boundaries, so two of them pass before looking
  task automatic hold_step(input logic [7:0] cnf, input logic [7:0] mtx, input logic rbw);
    wr(`PSC_A_CNF2, cnf);
    wr(`PSC_A_MTX, mtx);
    if (rbw) wcmp(`PSC_A_RB_L, 12'h003);
    wait_end();
    wait_end();
    look();
  endtask
  task automatic cap_try(output logic hit);
    hit = 1'b0;
    fault_pin <= 1'b1;
    repeat (8) begin
      @(negedge sys_clk);
      hit |= (cap_evt === 1'b1);
    end
    @(posedge sys_clk);
    fault_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  initial begin
    rst_b = 1'b0;
    bus = '0;
    fast_on = 1'b0;
    slow_on = 1'b0;
    fault_pin = 1'b0;
    cmp_out = 1'b0;
    mismatches = 0;
    num_checks = 0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    for (int i = 8; i <= 14; i++) begin
      rdc(5'(i), `PSC_RESET_REG);
      wr(5'(i), 8'h5a);
      rdc(5'(i), 8'h5a);
      wr(5'(i), 8'h00);
    end
    wr(5'h1f, 8'hff);
    rdc(5'h1f, 8'h00);
    wr(`PSC_A_SA_H, 8'hfa);
    rdc(`PSC_A_SA_H, 8'h00);
    wr(`PSC_A_RA_L, 8'h34);
    rdc(`PSC_A_RA_L, 8'h34);
    acc(1'b0, `PSC_A_RA_H, 8'h00);
    `CHK(q[3:0], 4'ha)
    wr(`PSC_A_CNF2, 8'h80);
    wcmp(`PSC_A_SB_L, 12'h123);
    wcmp(`PSC_A_RB_L, 12'h456);
    rdc(`PSC_A_SA_L, 8'h23);
    rdc(`PSC_A_RA_L, 8'h56);
    wr(`PSC_A_CNF2, 8'h00);
    look();
    `CHK(snap, 7'b000_11_11)
    wr(`PSC_A_CNF2, 8'h04);
    look();
    `CHK(snap, 7'b000_00_00)
    for (int i = 0; i < 4; i++) wcmp(5'(2 * i), 12'(i));
    wr(`PSC_A_OCFG, 8'h0f);
    wr(`PSC_A_MTX, 8'hff);
    wr(`PSC_A_CNF2, 8'h03);
    look();
    `CHK({snap, oe_b, oe_a}, 11'b000_00_00_1111)
    fast_on <= 1'b1;
    wr(`PSC_A_CTL2, 8'h01);
    wait_end();
    look();
    `CHK(snap, 7'b100_11_11)
    // Compares sit at 0..3 and the counter sweeps 0..3, so every register matches
    m_seen = 4'h0;
    repeat (40) begin
      @(negedge sys_clk);
      m_seen |= cmatch;
    end
    @(posedge sys_clk);
    `CHK(m_seen, 4'hf)
    wr(`PSC_A_MTX, 8'hee);
    for (int m = 0; m < 3; m++) begin
      wr(`PSC_A_CNF2, {3'b000, 2'(m), 3'b011});
      wait_end();
      wait_end();
      `CHK(seen, (m == 0) ? 2'b00 : 2'b11)
    end
    hold_step(8'h03, 8'hff, 1'b0);
    hold_step(8'h23, 8'h00, 1'b0);
    `CHK(snap, 7'b100_11_11)
    hold_step(8'h03, 8'h00, 1'b0);
    `CHK(snap, 7'b100_00_00)
    hold_step(8'h43, 8'hff, 1'b0);
    `CHK(snap, 7'b100_00_00)
    hold_step(8'h43, 8'hff, 1'b1);
    `CHK(snap, 7'b100_11_11)
    hold_step(8'h63, 8'h00, 1'b1);
    `CHK(snap, 7'b100_00_00)
    hold_step(8'h03, 8'hff, 1'b0);
    wr(`PSC_A_CTL2, 8'h09);
    fault_pin <= 1'b1;
    look();
    `CHK(snap, 7'b100_00_11)
    fault_pin <= 1'b0;
    wr(`PSC_A_FRCB, 8'h40);
    wr(`PSC_A_CTL2, 8'h11);
    fault_pin <= 1'b1;
    look();
    `CHK(snap, 7'b100_11_11)
    cmp_out <= 1'b1;
    look();
    `CHK(snap, 7'b100_11_00)
    fault_pin <= 1'b0;
    cmp_out <= 1'b0;
    wr(`PSC_A_CTL2, 8'h01);
    wr(`PSC_A_FRCA, 8'h80);
    cap_try(f);
    `CHK(f, 1'b1)
    `CHK(cap_val[11:2], 10'h000)
    wr(`PSC_A_FRCA, 8'h00);
    cap_try(f);
    `CHK(f, 1'b0)
    for (int k = 0; k < 4; k++) begin
      wr(`PSC_A_CTL2, {2'(k), 6'h01});
      wait_end();
      per_cycle(n);
      if (k == 0) n0 = n;
      `CHK(n, n0 * fac[k])
    end
    wr(`PSC_A_CTL2, 8'h01);
    wr(`PSC_A_CNF2, 8'h01);
    fast_on <= 1'b0;
    wait_ev(50, f);
    wait_ev(300, f);
    `CHK(f, 1'b0)
    slow_on <= 1'b1;
    per_cycle(n);
    `CHK(n, n0)
    fast_on <= 1'b1;
    slow_on <= 1'b0;
    wr(`PSC_A_CNF2, 8'h03);
    wr(`PSC_A_CTL0, 8'h04);
    look();
    `CHK(snap[6:4], 3'b101)
    wr(`PSC_A_CTL1, 8'h04);
    look();
    `CHK(snap[6:4], 3'b111)
    wr(`PSC_A_CTL2, 8'h00);
    look();
    `CHK(snap[6:4], 3'b000)
    wr(`PSC_A_CTL1, 8'h01);
    wr(`PSC_A_CTL2, 8'h04);
    look();
    `CHK(snap[6:4], 3'b111)
    wr(`PSC_A_CTL0, 8'h00);
    wr(`PSC_A_CTL1, 8'h00);
    wr(`PSC_A_CTL2, 8'h05);
    look();
    `CHK(snap[6:4], 3'b100)
    wr(`PSC_A_CTL2, 8'hc3);
    wait_end();
    wr(`PSC_A_CTL2, 8'hc2);
    look();
    // Run request level drops at once; the matrix levels show the engine still going
    `CHK(snap[3:2], 2'b11)
    wait_end();
    look();
    look();
    `CHK(snap[3:2], 2'b00)
    close_out();
  end
endmodule
